// ==== logic/ccr_defs.svh ====
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// I/O ports
`define CCR_ADDR_PORT 16'h0CF8
`define CCR_DATA_PORT 16'h0CFC
`define CCR_FULL_BE 4'hF

// Target-select register
`define CCR_TSEL_RESET 32'h0000_0000
`define CCR_TSEL_WMASK 32'h80FF_FFFC
`define CCR_EN_BIT 31
`define CCR_BUS_MSB 23
`define CCR_BUS_LSB 16
`define CCR_DEV_MSB 15
`define CCR_DEV_LSB 11
`define CCR_FUNC_MSB 10
`define CCR_FUNC_LSB 8
`define CCR_REG_MSB 7
`define CCR_REG_LSB 2

// Routing constants
`define CCR_PRIMARY_BUS 8'h00
`define CCR_BUS_ZERO 8'h00
`define CCR_FUNC_ZERO 3'h0
`define CCR_INT_DEV_MASK 32'h0000_004F
`define CCR_TYPE0_LOW 2'h0
`define CCR_TYPE1_LOW 2'h1
`define CCR_IDSEL_W 16
`define CCR_IGNORED_RDATA 32'hFFFF_FFFF
`define CCR_WRITE_RDATA 32'h0000_0000

`endif

// ==== logic/ccr_pkg.sv ====
package ccr_pkg;

    typedef enum logic [2:0] {
        ccr_tgt_internal,
        ccr_tgt_hub_t0,
        ccr_tgt_hub_t1,
        ccr_tgt_gfx_t0,
        ccr_tgt_gfx_t1,
        ccr_tgt_hub_io
    } ccr_target_t;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } ccr_io_req_t;

    typedef struct packed {
        ccr_target_t target;
        logic write;
        logic [31:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } ccr_route_t;

endpackage

// ==== logic/ccr_idsel_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_idsel_decode (
    // Device number
    input wire logic [4:0] dev,
    // One-hot select lines, all zero when dev is 16 to 31
    output logic [`CCR_IDSEL_W-1:0] idsel
);
    import ccr_pkg::*;

    always_comb begin
        idsel = '0;
        if (!dev[4]) begin
            idsel[dev[3:0]] = 1'b1;
        end
    end

endmodule

`default_nettype wire

// ==== logic/ccr_router.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"


module ccr_router (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Processor I/O request
    input wire logic io_req_valid,
    output logic io_req_ready,
    input wire ccr_pkg::ccr_io_req_t io_req,
    // Processor I/O response
    output logic io_resp_valid,
    output logic [31:0] io_resp_rdata,
    // Bridge bus numbers
    input wire logic [7:0] secondary_bus_num,
    input wire logic [7:0] subordinate_bus_num,
    output logic [7:0] primary_bus_num,
    // Routed cycle
    output logic route_valid,
    input wire logic route_ready,
    output ccr_pkg::ccr_route_t route,
    input wire logic route_done,
    input wire logic [31:0] route_rdata,
    // Target-select contents
    output logic [31:0] cfg_target_select,
    output logic cfg_access_enable,
    // Bridge status event
    output logic gfx_master_abort
);
    import ccr_pkg::*;

    typedef enum logic [1:0] {
        ccr_st_idle,
        ccr_st_issue,
        ccr_st_wait,
        ccr_st_resp
    } ccr_state_t;

    ccr_state_t state_reg;
    ccr_state_t state_next;
    logic [31:0] tsel_reg;
    logic [31:0] tsel_next;
    ccr_route_t route_reg;
    ccr_route_t route_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic abort_pend_reg;
    logic abort_pend_next;
    logic abort_pulse_reg;
    logic abort_pulse_next;

    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
    logic [5:0] regnum;
    logic [`CCR_IDSEL_W-1:0] idsel;
    logic hit_addr_port;
    logic hit_data_port;
    logic full_access;
    ccr_target_t cfg_target;
    logic cfg_ignore;
    logic [31:0] cfg_addr;

    function automatic logic is_internal_dev(input logic [4:0] d);
        logic [31:0] m;
        m = `CCR_INT_DEV_MASK;
        return m[d];
    endfunction

    assign bus = tsel_reg[`CCR_BUS_MSB:`CCR_BUS_LSB];
    assign dev = tsel_reg[`CCR_DEV_MSB:`CCR_DEV_LSB];
    assign func = tsel_reg[`CCR_FUNC_MSB:`CCR_FUNC_LSB];
    assign regnum = tsel_reg[`CCR_REG_MSB:`CCR_REG_LSB];

    ccr_idsel_decode u_idsel (
        .dev(dev),
        .idsel(idsel)
    );

    assign hit_addr_port = io_req.addr == `CCR_ADDR_PORT;
    assign hit_data_port = io_req.addr == `CCR_DATA_PORT;
    assign full_access = io_req.byte_en == `CCR_FULL_BE;

    // Configuration target decode from the current target-select contents
    always_comb begin
        cfg_target = ccr_tgt_hub_t1;
        cfg_ignore = 1'b0;
        cfg_addr = {8'h00, bus, dev, func, regnum, `CCR_TYPE1_LOW};
        if (bus == `CCR_BUS_ZERO) begin
            if (is_internal_dev(dev)) begin
                cfg_target = ccr_tgt_internal;
                cfg_ignore = func != `CCR_FUNC_ZERO;
                cfg_addr = {8'h00, bus, dev, func, regnum, `CCR_TYPE0_LOW};
            end else begin
                cfg_target = ccr_tgt_hub_t0;
                cfg_addr = {8'h00, bus, dev, func, regnum, `CCR_TYPE0_LOW};
            end
        end else if (bus == secondary_bus_num) begin
            cfg_target = ccr_tgt_gfx_t0;
            cfg_addr = {idsel, 5'h00, func, regnum, `CCR_TYPE0_LOW};
        end else if (bus > secondary_bus_num && bus <= subordinate_bus_num) begin
            cfg_target = ccr_tgt_gfx_t1;
        end else begin
            cfg_target = ccr_tgt_hub_t1;
        end
    end

    // Request sequencing
    always_comb begin
        state_next = state_reg;
        tsel_next = tsel_reg;
        route_next = route_reg;
        rdata_next = rdata_reg;
        abort_pend_next = abort_pend_reg;
        abort_pulse_next = 1'b0;
        unique case (state_reg)
            ccr_st_idle: begin
                if (io_req_valid) begin
                    if (hit_addr_port && full_access) begin
                        if (io_req.write) begin
                            tsel_next = io_req.wdata & `CCR_TSEL_WMASK;
                            rdata_next = `CCR_WRITE_RDATA;
                        end else begin
                            rdata_next = tsel_reg;
                        end
                        state_next = ccr_st_resp;
                    end else if (hit_data_port && tsel_reg[`CCR_EN_BIT]) begin
                        if (cfg_ignore) begin
                            rdata_next = io_req.write ? `CCR_WRITE_RDATA
                                                      : `CCR_IGNORED_RDATA;
                            state_next = ccr_st_resp;
                        end else begin
                            route_next.target = cfg_target;
                            route_next.write = io_req.write;
                            route_next.addr = cfg_addr;
                            route_next.byte_en = io_req.byte_en;
                            route_next.wdata = io_req.wdata;
                            abort_pend_next = cfg_target == ccr_tgt_gfx_t0 && dev[4];
                            state_next = ccr_st_issue;
                        end
                    end else begin
                        route_next.target = ccr_tgt_hub_io;
                        route_next.write = io_req.write;
                        route_next.addr = {16'h0000, io_req.addr};
                        route_next.byte_en = io_req.byte_en;
                        route_next.wdata = io_req.wdata;
                        abort_pend_next = 1'b0;
                        state_next = ccr_st_issue;
                    end
                end
            end
            ccr_st_issue: begin
                if (route_ready) begin
                    state_next = ccr_st_wait;
                end
            end
            ccr_st_wait: begin
                if (route_done) begin
                    rdata_next = route.write ? `CCR_WRITE_RDATA : route_rdata;
                    abort_pulse_next = abort_pend_reg;
                    abort_pend_next = 1'b0;
                    state_next = ccr_st_resp;
                end
            end
            ccr_st_resp: begin
                state_next = ccr_st_idle;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ccr_st_idle;
            tsel_reg <= `CCR_TSEL_RESET;
            route_reg <= '0;
            rdata_reg <= '0;
            abort_pend_reg <= 1'b0;
            abort_pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tsel_reg <= tsel_next;
            route_reg <= route_next;
            rdata_reg <= rdata_next;
            abort_pend_reg <= abort_pend_next;
            abort_pulse_reg <= abort_pulse_next;
        end
    end

    assign io_req_ready = state_reg == ccr_st_idle;
    assign io_resp_valid = state_reg == ccr_st_resp;
    assign io_resp_rdata = rdata_reg;
    assign route_valid = state_reg == ccr_st_issue;
    assign route = route_reg;
    assign primary_bus_num = `CCR_PRIMARY_BUS;
    assign cfg_target_select = tsel_reg;
    assign cfg_access_enable = tsel_reg[`CCR_EN_BIT];
    assign gfx_master_abort = abort_pulse_reg;

endmodule

`default_nettype wire

// ==== sim/ccr_route_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_route_model (
    // Clock, reset, pace
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    // Route handshake
    input wire logic route_valid,
    output logic route_ready,
    input wire ccr_pkg::ccr_route_t route,
    output logic route_done,
    output logic [31:0] route_rdata
);
    logic [2:0] cnt;
    always_ff @(posedge clk) begin
        route_done <= 1'h0;
        route_rdata <= ~route_rdata;
        route_ready <= route_valid && !route_ready && !route_done && cnt == 3'h0;
        if (rst) begin
            cnt <= 3'h0;
            route_rdata <= 32'h0000_0000;
        end else if (route_valid && route_ready) begin
            cnt <= slow ? 3'h6 : 3'h1;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            route_done <= cnt == 3'h1;
            if (cnt == 3'h1) begin
                route_rdata <= ~route.addr;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/ccr_router_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"
module ccr_router_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic io_req_valid,
    input wire logic io_req_ready,
    input wire ccr_pkg::ccr_io_req_t io_req,
    input wire logic io_resp_valid,
    input wire logic [7:0] secondary_bus_num,
    input wire logic [7:0] subordinate_bus_num,
    input wire logic [7:0] primary_bus_num,
    input wire logic route_valid,
    input wire ccr_pkg::ccr_route_t route,
    input wire logic [31:0] cfg_target_select,
    input wire logic cfg_access_enable,
    input wire logic gfx_master_abort
);
    import ccr_pkg::*;
    logic [7:0] bus;
    logic g0, g1, h1, wr;
    assign bus = cfg_target_select[23:16];
    assign g0 = route_valid && route.target == ccr_tgt_gfx_t0;
    assign g1 = route_valid && route.target == ccr_tgt_gfx_t1;
    assign h1 = route_valid && route.target == ccr_tgt_hub_t1;
    assign wr = io_req_valid && io_req_ready && io_req.write && io_req.addr == `CCR_ADDR_PORT;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_primary_zero: assert property (primary_bus_num == 8'h00)
        else $error("primary bus");
    a_tsel_fields: assert property (cfg_target_select[30:24] == 7'h00
        && cfg_access_enable == cfg_target_select[31]) else $error("reserved or enable");
    a_reg_write: assert property (wr && io_req.byte_en == 4'hF |=>
        cfg_target_select == ($past(io_req.wdata) & `CCR_TSEL_WMASK)) else $error("tsel write");
    a_gfx0_idsel: assert property (g0 |-> route.addr[31:16] == (cfg_target_select[15] ?
        16'h0000 : 16'h0001 << cfg_target_select[14:11])) else $error("idsel");
    a_gfx0_bus: assert property (g0 |-> bus == secondary_bus_num && bus != 8'h00)
        else $error("type 0 bus");
    a_gfx1_form: assert property (g1 |-> bus > secondary_bus_num && bus <= subordinate_bus_num
        && route.addr == {8'h00, cfg_target_select[23:2], 2'h1}) else $error("type 1 form");
    a_hub1_range: assert property (h1 |-> bus != 8'h00
        && (bus < secondary_bus_num || bus > subordinate_bus_num)) else $error("hub type 1");
    a_abort_pulse: assert property (gfx_master_abort |-> io_resp_valid && g0 == 1'h0
        && route.target == ccr_tgt_gfx_t0 && route.addr[31:16] == 16'h0000) else $error("abort");
    c_gfx0: cover property (g0);
    c_gfx1: cover property (g1);
    c_abort: cover property (gfx_master_abort);
endmodule
bind ccr_router ccr_router_asserts u_chk (.clk, .rst, .io_req_valid, .io_req_ready, .io_req,
    .io_resp_valid, .secondary_bus_num, .subordinate_bus_num, .primary_bus_num, .route_valid,
    .route, .cfg_target_select, .cfg_access_enable, .gfx_master_abort);
`default_nettype wire

// ==== sim/tb_config_cycle_router.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_config_cycle_router;
    import ccr_pkg::*;
    logic clk = 1'h0, rst = 1'h1, vld = 1'h0, slow = 1'h0, ab_seen;
    logic rdy, rsp, rv, rr, rd, ab, en;
    logic [7:0] sec = 8'h00, sub = 8'h00, pri;
    logic [31:0] rsd, rrd, ts;
    ccr_io_req_t req = '0;
    ccr_route_t rt;
    int bad_count = 0, checked = 0, i;
    ccr_router dut (.clk(clk), .rst(rst), .io_req_valid(vld), .io_req_ready(rdy), .io_req(req),
        .io_resp_valid(rsp), .io_resp_rdata(rsd), .secondary_bus_num(sec),
        .subordinate_bus_num(sub), .primary_bus_num(pri), .route_valid(rv), .route_ready(rr),
        .route(rt), .route_done(rd), .route_rdata(rrd), .cfg_target_select(ts),
        .cfg_access_enable(en), .gfx_master_abort(ab));
    ccr_route_model far (.clk(clk), .rst(rst), .slow(slow), .route_valid(rv),
        .route_ready(rr), .route(rt), .route_done(rd), .route_rdata(rrd));
    initial forever #2 clk = ~clk;
    task automatic chk(input logic ok);
        checked++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: mismatch", $time);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic [31:0] exp);
        int n;
        @(negedge clk);
        req = '{w, a, be, d};
        vld = 1'h1;
        for (n = 0; rdy !== 1'h1 && n < 50; n++) @(negedge clk);
        @(negedge clk);
        vld = 1'h0;
        for (n = 0; rsp !== 1'h1 && n < 50; n++) @(negedge clk);
        ab_seen = ab;
        chk(rsp === 1'h1 && rsd === exp);
    endtask
    task automatic probe(input logic [31:0] cfg, input ccr_target_t t, input logic [31:0] ra);
        acc(1'h1, 16'h0CF8, 4'hF, cfg, 32'h0000_0000);
        acc(1'h0, 16'h0CFC, 4'hF, 32'h0000_0000, ~ra);
        chk(rt.target === t && rt.addr === ra);
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'h0;
        chk(pri === 8'h00);
        acc(1'h0, 16'h0CF8, 4'hF, 32'h0000_0000, 32'h0000_0000);
        acc(1'h1, 16'h0CF8, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
        acc(1'h0, 16'h0CF8, 4'hF, 32'h0000_0000, 32'h80FF_FFFC);
        acc(1'h1, 16'h0CF8, 4'h3, 32'h0000_0000, 32'h0000_0000);
        chk(rt.target === ccr_tgt_hub_io && rt.addr === 32'h0000_0CF8 && ts === 32'h80FF_FFFC);
        chk(rt.write === 1'h1 && rt.byte_en === 4'h3);
        for (i = 0; i < 8; i++) begin
            probe(32'h8000_0014 | 32'(i << 11), (8'h4F >> i) & 1 ? ccr_tgt_internal : ccr_tgt_hub_t0,
                32'h0000_0014 | 32'(i << 11));
        end
        acc(1'h1, 16'h0CF8, 4'hF, 32'h8000_0900, 32'h0000_0000);
        acc(1'h0, 16'h0CFC, 4'hF, 32'h0000_0000, 32'hFFFF_FFFF);
        sec = 8'h02;
        sub = 8'h05;
        for (i = 0; i < 32; i++) begin
            slow = i[0];
            probe(32'h8002_0208 | 32'(i << 11), ccr_tgt_gfx_t0,
                {i < 16 ? 16'(1 << i) : 16'h0000, 16'h0208});
            chk(ab_seen === (i > 15));
        end
        for (i = 1; i < 7; i++) begin
            if (i != 2) begin
                probe(32'h8000_1B04 | 32'(i << 16), i > 2 && i < 6 ? ccr_tgt_gfx_t1 : ccr_tgt_hub_t1,
                    32'h0000_1B05 | 32'(i << 16));
            end
        end
        acc(1'h1, 16'h0CFC, 4'hC, 32'h1234_5678, 32'h0000_0000);
        chk(rt.write === 1'h1 && rt.byte_en === 4'hC && rt.wdata === 32'h1234_5678);
        chk(rt.target === ccr_tgt_hub_t1 && rt.addr === 32'h0006_1B05);
        probe(32'h0002_0000, ccr_tgt_hub_io, 32'h0000_0CFC);
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
